// ---- common/elad_pkg.sv ----
package elad_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] ADR_INSTR  = 8'h00;
  localparam logic [7:0] ADR_SRC1   = 8'h04;
  localparam logic [7:0] ADR_SRC2   = 8'h08;
  localparam logic [7:0] ADR_DSTV   = 8'h0C;
  localparam logic [7:0] ADR_CTRL   = 8'h10;
  localparam logic [7:0] ADR_RESULT = 8'h14;
  localparam logic [7:0] ADR_STATUS = 8'h18;
  localparam logic [7:0] ADR_SBOARD = 8'h1C;
  // control register bits and reset value (supervisor mode)
  localparam int         CTL_SUP    = 0;
  localparam int         CTL_CARRY  = 1;
  localparam int         CTL_MMASK  = 2;
  localparam logic [2:0] CTL_RST    = 3'h1;
  // instruction field positions
  localparam int F_UPPER = 26;
  localparam int F_COMPL = 10;
  localparam int F_TYREG = 10;
  localparam int F_TYIMM = 26;
  localparam int F_CIN   = 9;
  localparam int F_SCALE = 9;
  localparam int F_COUT  = 8;
  localparam int F_USER  = 8;
  localparam int CR_LSB  = 5;
  localparam int CR_AW   = 3;
  localparam int CR_NUM  = 8;
  // opcodes
  localparam logic [4:0] LG_AND   = 5'h08;
  localparam logic [4:0] LG_MASK  = 5'h09;
  localparam logic [4:0] LG_XOR   = 5'h0A;
  localparam logic [4:0] LG_OR    = 5'h0B;
  localparam logic [2:0] AR_CLASS = 3'h3;
  localparam logic [2:0] CP_CLASS = 3'h4;
  localparam logic [5:0] P_REG    = 6'h3D;
  localparam logic [4:0] P_SWAPI  = 5'h00;
  localparam logic [3:0] S_SWAPR  = 4'h0;
  localparam logic [2:0] AR_ADDU  = 3'h0;
  localparam logic [2:0] AR_SUBU  = 3'h1;
  localparam logic [2:0] AR_DIVU  = 3'h2;
  localparam logic [2:0] AR_MUL   = 3'h3;
  localparam logic [2:0] AR_ADD   = 3'h4;
  localparam logic [2:0] AR_SUB   = 3'h5;
  localparam logic [2:0] AR_DIV   = 3'h6;
  localparam logic [1:0] CR_LD    = 2'h1;
  localparam logic [1:0] CR_ST    = 2'h2;
  localparam logic [1:0] CR_XC    = 2'h3;
  localparam logic [2:0] UNIT_GEN = 3'h0;
  localparam logic [2:0] UNIT_FP  = 3'h1;
  localparam logic [1:0] SZ_DBL   = 2'h1;
  localparam int         SCALE_W  = 2;
  typedef enum logic [3:0] {
    EX_NONE  = 4'h0,
    EX_PRIV  = 4'h1,
    EX_DACC  = 4'h2,
    EX_MISAL = 4'h3,
    EX_SFU   = 4'h4,
    EX_UNIMP = 4'h5,
    EX_DIVZ  = 4'h6,
    EX_ILL   = 4'h7
  } elad_exc_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_SYNC  = 2'h1,
    ST_READ  = 2'h2,
    ST_WRITE = 2'h3
  } elad_st_t;
endpackage : elad_pkg

// ---- core/elad_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module elad_core (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        pipe_busy_i,
  input  wire logic        dm_ack_i,
  input  wire logic        dm_err_i,
  input  wire logic [31:0] dm_rdata_i,
  output logic             dm_req_o,
  output logic             dm_we_o,
  output logic             dm_lock_o,
  output logic      [31:0] dm_addr_o,
  output logic      [3:0]  dm_sel_o,
  output logic      [31:0] dm_wdata_o,
  output logic      [31:0] sb_busy_o
);
  typedef struct packed {
    elad_pkg::elad_st_t                    st;
    logic                                  ack;
    logic [31:0]                           rdat;
    logic [31:0]                           instr;
    logic [31:0]                           src1;
    logic [31:0]                           src2;
    logic [31:0]                           dstv;
    logic [2:0]                            ctl;
    logic [31:0]                           res;
    elad_pkg::elad_exc_t                   exc;
    logic                                  sfault;
    logic                                  fpd;
    logic                                  dwe;
    logic [2:0]                            sfu;
    logic [5:0]                            sz;
    logic [31:0]                           sb;
    logic [31:0]                           addr;
    logic [31:0]                           wdat;
    logic [3:0]                            sel;
    logic                                  word;
    logic [elad_pkg::CR_NUM-1:0][31:0]     gcr;
    logic [elad_pkg::CR_NUM-1:0][31:0]     fcr;
  } elad_state_t;

  elad_state_t q_q, d_d;

  // byte-lane merge for bus writes
  function automatic logic [31:0] elad_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction : elad_merge

  // bus decode and instruction fields
  logic        acc, wr, iss, sup;
  logic [31:0] iw;
  logic [5:0]  p6;
  logic [4:0]  m5, s5, rd;
  logic [15:0] imm;
  localparam int CR_AW_W = elad_pkg::CR_AW;
  logic [2:0]  unit, bank;
  logic [CR_AW_W-1:0] crn;
  assign acc  = wb_cyc_i && wb_stb_i && !q_q.ack;
  assign wr   = acc && wb_we_i;
  assign iw   = elad_merge(q_q.instr, wb_dat_i, wb_sel_i);
  assign iss  = wr && wb_adr_i == elad_pkg::ADR_INSTR && q_q.st == elad_pkg::ST_IDLE;
  assign sup  = q_q.ctl[elad_pkg::CTL_SUP]; // mode sampled at issue
  assign p6   = iw[31:26];
  assign m5   = iw[31:27];
  assign s5   = iw[15:11];
  assign rd   = iw[25:21];
  assign imm  = iw[15:0];
  assign unit = iw[28:26];
  assign bank = iw[13:11];
  assign crn  = iw[elad_pkg::CR_LSB +: CR_AW_W];

  // next state: bus slave, decode/execute, swap sequencer
  always_comb begin
    logic [31:0] b, ix, hm, ea, c;
    logic [32:0] sm;
    logic        ci, cy, reg_f, sw_imm, sw_reg, w;
    logic [2:0]  a3;
    b = '0; ix = '0; hm = '0; ea = '0; c = '0; sm = '0;
    ci = 1'b0; cy = q_q.ctl[elad_pkg::CTL_CARRY]; a3 = '0; w = 1'b0;
    reg_f  = (p6 == elad_pkg::P_REG);
    sw_imm = (m5 == elad_pkg::P_SWAPI);
    sw_reg = reg_f && iw[15:12] == elad_pkg::S_SWAPR;
    d_d = q_q;
    d_d.ack = acc;
    if (acc) begin
      case (wb_adr_i)
        elad_pkg::ADR_INSTR:  d_d.rdat = q_q.instr;
        elad_pkg::ADR_SRC1:   d_d.rdat = q_q.src1;
        elad_pkg::ADR_SRC2:   d_d.rdat = q_q.src2;
        elad_pkg::ADR_DSTV:   d_d.rdat = q_q.dstv;
        elad_pkg::ADR_CTRL:   d_d.rdat = {29'h0, q_q.ctl};
        elad_pkg::ADR_RESULT: d_d.rdat = q_q.res;
        elad_pkg::ADR_STATUS: d_d.rdat = {10'h0, q_q.sz, q_q.instr[25:21], q_q.dwe, q_q.sfu, q_q.fpd,
                                          q_q.sfault, q_q.st != elad_pkg::ST_IDLE, q_q.exc};
        elad_pkg::ADR_SBOARD: d_d.rdat = q_q.sb;
        default:              d_d.rdat = '0;
      endcase
    end
    // software register writes
    if (wr) begin
      case (wb_adr_i)
        elad_pkg::ADR_SRC1: d_d.src1 = elad_merge(q_q.src1, wb_dat_i, wb_sel_i);
        elad_pkg::ADR_SRC2: d_d.src2 = elad_merge(q_q.src2, wb_dat_i, wb_sel_i);
        elad_pkg::ADR_DSTV: d_d.dstv = elad_merge(q_q.dstv, wb_dat_i, wb_sel_i);
        elad_pkg::ADR_CTRL: if (wb_sel_i[0]) d_d.ctl = wb_dat_i[2:0];
        default: ;
      endcase
    end
    // instruction issue; undecoded bits never looked at
    if (iss) begin
      d_d.instr  = iw;
      d_d.exc    = elad_pkg::EX_NONE;
      d_d.sfault = 1'b0;
      d_d.fpd    = 1'b0;
      d_d.dwe    = 1'b0;
      d_d.sfu    = '0;
      if (m5 >= elad_pkg::LG_AND && m5 <= elad_pkg::LG_OR) begin
        // immediate logic on the selected half
        hm = iw[elad_pkg::F_UPPER] ? {imm, 16'h0} : {16'h0, imm};
        case (m5)
          elad_pkg::LG_AND:  d_d.res = q_q.src1 & (iw[elad_pkg::F_UPPER] ? {imm, 16'hFFFF}
                                                                         : {16'hFFFF, imm});
          elad_pkg::LG_MASK: d_d.res = q_q.src1 & hm;
          elad_pkg::LG_XOR:  d_d.res = q_q.src1 ^ hm;
          default:           d_d.res = q_q.src1 | hm;
        endcase
        d_d.dwe = 1'b1;
      end else if (p6[5:3] == elad_pkg::AR_CLASS ||
                   (reg_f && iw[15:13] == elad_pkg::AR_CLASS)) begin
        // integer arithmetic, immediate or register form
        a3 = reg_f ? iw[12:10] : p6[2:0];
        b  = reg_f ? q_q.src2 : {16'h0, imm};
        ci = reg_f && iw[elad_pkg::F_CIN];
        d_d.dwe = 1'b1;
        case (a3)
          elad_pkg::AR_ADDU, elad_pkg::AR_ADD: begin
            sm = {1'b0, q_q.src1} + {1'b0, b} + {32'h0, ci & cy};
            d_d.res = sm[31:0];
          end
          elad_pkg::AR_SUBU, elad_pkg::AR_SUB: begin
            sm = {1'b0, q_q.src1} + {1'b0, ~b} + {32'h0, ci ? cy : 1'b1};
            d_d.res = sm[31:0];
          end
          elad_pkg::AR_MUL: d_d.res = q_q.src1 * b;
          elad_pkg::AR_DIVU, elad_pkg::AR_DIV: begin
            if (b == '0) begin
              d_d.exc = elad_pkg::EX_DIVZ;
              d_d.dwe = 1'b0;
            end else if (a3 == elad_pkg::AR_DIV) d_d.res = $signed(q_q.src1) / $signed(b);
            else d_d.res = q_q.src1 / b;
          end
          default: begin
            c = {20'h0, q_q.src1 >= b, q_q.src1 < b, q_q.src1 <= b, q_q.src1 > b,
                 $signed(q_q.src1) >= $signed(b), $signed(q_q.src1) < $signed(b),
                 $signed(q_q.src1) <= $signed(b), $signed(q_q.src1) > $signed(b),
                 q_q.src1 != b, q_q.src1 == b, 2'b00};
            d_d.res = c;
          end
        endcase
        if (reg_f && iw[elad_pkg::F_COUT] && a3 != elad_pkg::AR_MUL &&
            !a3[1]) d_d.ctl[elad_pkg::CTL_CARRY] = sm[32];
      end else if (reg_f && s5 >= elad_pkg::LG_AND && s5 <= elad_pkg::LG_OR) begin
        // register logic with optional complement
        b = iw[elad_pkg::F_COMPL] ? ~q_q.src2 : q_q.src2;
        case (s5)
          elad_pkg::LG_XOR: d_d.res = q_q.src1 ^ b;
          elad_pkg::LG_OR:  d_d.res = q_q.src1 | b;
          default:          d_d.res = q_q.src1 & b;
        endcase
        d_d.dwe = 1'b1;
      end else if (p6[5:3] == elad_pkg::CP_CLASS) begin
        if (unit == elad_pkg::UNIT_GEN) begin
          // control transfers by bank
          if (bank > elad_pkg::UNIT_FP) begin
            d_d.exc = elad_pkg::EX_SFU;
            d_d.sfu = bank;
          end else if (bank == elad_pkg::UNIT_GEN && !sup) begin
            d_d.exc = elad_pkg::EX_PRIV; // nothing changes
          end else begin
            // xcr reads the first source field, both fields agree
            if (s5[4:3] == elad_pkg::CR_LD || s5[4:3] == elad_pkg::CR_XC) begin
              d_d.res = bank[0] ? q_q.fcr[crn] : q_q.gcr[crn];
              d_d.dwe = 1'b1;
            end
            if (s5[4:3] == elad_pkg::CR_ST || s5[4:3] == elad_pkg::CR_XC) begin
              if (bank[0]) d_d.fcr[crn] = q_q.src1;
              else d_d.gcr[crn] = q_q.src1;
            end
          end
        end else if (unit == elad_pkg::UNIT_FP) begin
          // floating-point dispatch with size
          d_d.sz = iw[10:5];
          if (iw[10] || iw[8] || iw[6] || rd == 5'h0) d_d.exc = elad_pkg::EX_UNIMP;
          else d_d.fpd = 1'b1;
        end else begin
          d_d.exc = elad_pkg::EX_SFU; // reserved units
          d_d.sfu = unit;
        end
      end else if (sw_imm || sw_reg) begin
        // memory swap setup
        w  = sw_imm ? iw[elad_pkg::F_TYIMM] : iw[elad_pkg::F_TYREG];
        ix = sw_imm ? {16'h0, imm} :
             (iw[elad_pkg::F_SCALE] && w) ? (q_q.src2 << elad_pkg::SCALE_W) : q_q.src2;
        ea = q_q.src1 + ix;
        if (sw_reg && iw[elad_pkg::F_USER] && !sup) d_d.exc = elad_pkg::EX_PRIV;
        else if (w && ea[1:0] != 2'h0 && !q_q.ctl[elad_pkg::CTL_MMASK])
          d_d.exc = elad_pkg::EX_MISAL;
        else begin
          if (w) ea[1:0] = 2'h0;
          d_d.addr = ea;
          d_d.word = w;
          d_d.sel  = w ? 4'hF : (4'h1 << ea[1:0]);
          d_d.wdat = w ? q_q.dstv : {4{q_q.dstv[7:0]}};
          d_d.sb[rd] = 1'b1;
          d_d.st = elad_pkg::ST_SYNC;
        end
      end else begin
        d_d.exc = elad_pkg::EX_ILL;
      end
    end
    // swap sequencer: wait for pipe, then locked read and write
    case (q_q.st)
      elad_pkg::ST_SYNC: if (!pipe_busy_i) d_d.st = elad_pkg::ST_READ;
      elad_pkg::ST_READ: if (dm_ack_i) begin
        d_d.sb = '0; // read done, destination free
        if (dm_err_i) begin
          d_d.exc = elad_pkg::EX_DACC;
          d_d.st  = elad_pkg::ST_IDLE;
        end else begin
          d_d.res = q_q.word ? dm_rdata_i :
                    {24'h0, dm_rdata_i[{q_q.addr[1:0], 3'h0} +: 8]};
          d_d.dwe = 1'b1;
          d_d.st  = elad_pkg::ST_WRITE; // no release between halves
        end
      end
      elad_pkg::ST_WRITE: if (dm_ack_i) begin
        if (dm_err_i) begin
          d_d.exc    = elad_pkg::EX_DACC;
          d_d.sfault = 1'b1;
        end
        d_d.st = elad_pkg::ST_IDLE;
      end
      default: ;
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_q     <= '0;
      q_q.ctl <= elad_pkg::CTL_RST;
    end else begin
      q_q <= d_d;
    end
  end

  // outputs
  assign wb_ack_o   = q_q.ack;
  assign wb_dat_o   = q_q.rdat;
  assign dm_req_o   = q_q.st == elad_pkg::ST_READ || q_q.st == elad_pkg::ST_WRITE;
  assign dm_lock_o  = dm_req_o;
  assign dm_we_o    = q_q.st == elad_pkg::ST_WRITE;
  assign dm_addr_o  = q_q.addr;
  assign dm_sel_o   = q_q.sel;
  assign dm_wdata_o = q_q.wdat;
  assign sb_busy_o  = q_q.sb;

  // checks
  logic reg_xor_c;
  assign reg_xor_c = p6 == elad_pkg::P_REG && s5 == elad_pkg::LG_XOR && iw[elad_pkg::F_COMPL];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // bus ack timing
  chk_bus_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  chk_bus_ack_next: assert property (acc |=> wb_ack_o) else $error("no ack");
  // swap pairing and lanes
  chk_swap_pair_lock: assert property (dm_req_o && !dm_we_o && dm_ack_i && !dm_err_i
    |=> dm_we_o && dm_lock_o) else $error("write half not locked");
  chk_swap_sb_busy: assert property (q_q.st inside {elad_pkg::ST_SYNC, elad_pkg::ST_READ}
    |-> sb_busy_o != '0) else $error("destination not busy");
  chk_swap_sync_wait: assert property ($rose(q_q.st == elad_pkg::ST_READ)
    |-> !$past(pipe_busy_i)) else $error("swap started with busy pipe");
  chk_swap_word_sel: assert property (dm_req_o && q_q.word |-> dm_sel_o == 4'hF)
    else $error("word swap lanes");
  chk_swap_byte_sel: assert property (dm_req_o && !q_q.word |-> $countones(dm_sel_o) == 1)
    else $error("byte swap lanes");
  // lock equals request
  chk_swap_lock_req: assert property (dm_lock_o == dm_req_o)
    else $error("lock and request differ");
  // word swaps aligned
  chk_swap_word_aln: assert property (dm_req_o && q_q.word
    |-> dm_addr_o[1:0] == 2'h0)
    else $error("word swap misaligned");
  // byte read zero extended
  chk_swap_byte_res: assert property (dm_req_o && !dm_we_o && !q_q.word
    && dm_ack_i && !dm_err_i |=> q_q.res[31:8] == '0)
    else $error("byte swap not zero extended");
  // scoreboard free in write
  chk_swap_sb_free: assert property (dm_we_o |-> sb_busy_o == '0)
    else $error("scoreboard held after read");
  // store fault flagged
  chk_swap_st_fault: assert property (dm_we_o && dm_ack_i && dm_err_i
    |=> q_q.sfault && q_q.exc == elad_pkg::EX_DACC)
    else $error("store fault not reported");
  // no issue while busy
  chk_busy_no_issue: assert property (q_q.st != elad_pkg::ST_IDLE
    |=> $stable(q_q.instr))
    else $error("issue during swap");
  // decode outcomes
  chk_xcr_user_priv: assert property (iss && p6 == {elad_pkg::CP_CLASS, elad_pkg::UNIT_GEN}
    && bank == elad_pkg::UNIT_GEN && !sup |=> q_q.exc == elad_pkg::EX_PRIV && $stable(q_q.gcr))
    else $error("user xcr not refused");
  chk_xor_compl: assert property (iss && reg_xor_c |=> q_q.res == ($past(q_q.src1) ^ ~$past(q_q.src2)))
    else $error("complemented xor wrong");
  chk_sfu_rsvd: assert property (iss && p6[5:3] == elad_pkg::CP_CLASS && unit > elad_pkg::UNIT_FP
    |=> q_q.exc == elad_pkg::EX_SFU && q_q.sfu == $past(unit)) else $error("reserved unit accepted");
  // reserved bank refused
  chk_bank_rsvd: assert property (iss && p6 == {elad_pkg::CP_CLASS, elad_pkg::UNIT_GEN}
    && bank > elad_pkg::UNIT_FP |=> q_q.exc == elad_pkg::EX_SFU)
    else $error("reserved bank accepted");
  // float size 1x refused
  chk_fp_size: assert property (iss && p6 == {elad_pkg::CP_CLASS, elad_pkg::UNIT_FP}
    && (iw[10] || iw[8] || iw[6]) |=> q_q.exc == elad_pkg::EX_UNIMP && !q_q.fpd)
    else $error("bad float size dispatched");
  // main scenarios
  cov_swap_done: cover property (dm_we_o && dm_ack_i && !dm_err_i);
  cov_store_fault: cover property (dm_we_o && dm_ack_i && dm_err_i);
  cov_cr_xchg: cover property (iss && p6[5:3] == elad_pkg::CP_CLASS && s5[4:3] == elad_pkg::CR_XC && sup);
  cov_byte_swap: cover property (dm_req_o && !q_q.word);
  cov_user_priv: cover property (q_q.exc == elad_pkg::EX_PRIV);
endmodule : elad_core
`default_nettype wire

// ---- tb/elad_dmem.sv ----
`timescale 1ns/1ps
`default_nettype none
// data memory model: answers after lat_i waiting cycles, may fault a store on command
module elad_dmem (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [1:0]  lat_i,
  input  wire logic        err_wr_i,
  output logic             ack_o,
  output logic             err_o,
  output logic      [31:0] rdata_o
);
  logic [31:0] mem [16];
  logic [1:0]  cnt_q;
  // known contents, mirrored by the bench
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 32'hC0DE0000 | i;
  end
  // one-cycle answer; read data is inverted once its hold time is over
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
      cnt_q   <= 2'h0;
      rdata_o <= 32'h0;
    end else if (ack_o) begin
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
      cnt_q   <= 2'h0;
      rdata_o <= ~rdata_o;
    end else if (req_i && cnt_q >= lat_i) begin
      ack_o   <= 1'b1;
      err_o   <= we_i & err_wr_i;
      rdata_o <= mem[addr_i[5:2]];
      for (int b = 0; b < 4; b++) begin
        if (we_i && !err_wr_i && sel_i[b]) mem[addr_i[5:2]][8*b+:8] <= wdata_i[8*b+:8];
      end
    end else if (req_i) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
endmodule : elad_dmem
`default_nettype wire

// ---- tb/elad_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module elad_core_tb;
  typedef struct {logic [31:0] e; logic [31:0] m;} elad_bx_t;
  typedef struct {logic [31:0] a; logic we; logic [3:0] sel; logic [31:0] wd, wm, sb;} elad_dx_t;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic        clk, rstn, cyc, stb, we, ack, pbusy, lerr, dreq, dwe, dlock, dack, derr;
  logic [7:0]  adr;
  logic [3:0]  sel, dsel;
  logic [1:0]  lat;
  logic [31:0] wdat, rdat, daddr, dwd, drd, sbb, a, b, r;
  logic [31:0] sh [16];
  logic [4:0]  ops [3] = '{elad_pkg::LG_AND, elad_pkg::LG_XOR, elad_pkg::LG_OR};
  integer      seed = 32'hd1e7;
  int          n_mismatch, checks;
  elad_bx_t    bq[$];
  elad_dx_t    dq[$];
  elad_core elad_core_inst (.clk_i(clk), .rstn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pipe_busy_i(pbusy),
    .dm_ack_i(dack), .dm_err_i(derr), .dm_rdata_i(drd), .dm_req_o(dreq), .dm_we_o(dwe), .dm_lock_o(dlock),
    .dm_addr_o(daddr), .dm_sel_o(dsel), .dm_wdata_o(dwd), .sb_busy_o(sbb));
  elad_dmem elad_dmem_inst (.clk_i(clk), .rstn_i(rstn), .req_i(dreq), .we_i(dwe), .addr_i(daddr),
    .sel_i(dsel), .wdata_i(dwd), .lat_i(lat), .err_wr_i(lerr), .ack_o(dack), .err_o(derr), .rdata_o(drd));
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1000000;
    bad("timeout");
    end_sim();
  end
  task automatic bad(input string s);
    n_mismatch++;
    $display("BAD %0t %s", $time, s);
  endtask : bad
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // classic single bus cycle; the expected read value is noted first
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d, e, m);
    int t;
    t = 0;
    bq.push_back('{e, m});
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, ad, d, 4'hF};
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (t >= 50) bad("bus hang");
    if (t >= 50) end_sim();
    {cyc, stb} <= 2'b00;
  endtask : bus
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d, 32'h0, 32'h0);
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, m);
    bus(1'b0, ad, 32'h0, e, m);
  endtask : rd
  task automatic iss(input logic [31:0] i, s1, s2, dv);
    wr(elad_pkg::ADR_SRC1, s1);
    wr(elad_pkg::ADR_SRC2, s2);
    wr(elad_pkg::ADR_DSTV, dv);
    wr(elad_pkg::ADR_INSTR, i);
  endtask : iss
  function automatic logic [31:0] rr(input logic [5:0] p, input logic [4:0] d, s, input logic [10:0] lo,
                                     input logic [4:0] s2);
    return {p, d, s, lo, s2};
  endfunction : rr
  function automatic logic [31:0] lg(input logic [4:0] o, input logic [31:0] x, y);
    if (o == elad_pkg::LG_AND) return x & y;
    if (o == elad_pkg::LG_XOR) return x ^ y;
    return x | y;
  endfunction : lg
  function automatic logic [31:0] ar(input logic [2:0] o, input logic [31:0] x, y);
    if (o[1:0] == 2'h0) return x + y;
    if (o[1:0] == 2'h1) return x - y;
    if (o[1:0] == 2'h2) return x / y;
    return x * y;
  endfunction : ar
  function automatic logic [31:0] xc(input logic [2:0] bank);
    return rr(6'h20, 5'h04, 5'h04, {2'b11, bank, 6'h03}, 5'h04);
  endfunction : xc
  // bus and data-port monitors compare against the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && bq.size() == 0) bad("stray ack");
    else if (ack === 1'b1) begin
      elad_bx_t x;
      x = bq.pop_front();
      if (x.m != 32'h0) checks++;
      if (x.m != 32'h0 && (rdat & x.m) !== (x.e & x.m)) $display("BAD %0t read %h exp %h", $time, rdat, x.e);
      if (x.m != 32'h0 && (rdat & x.m) !== (x.e & x.m)) n_mismatch++;
    end
    if (pbusy === 1'b1 && dreq !== 1'b0) bad("access while pipe busy");
    if (dreq === 1'b1 && dack === 1'b1 && dq.size() == 0) bad("stray access");
    else if (dreq === 1'b1 && dack === 1'b1) begin
      elad_dx_t y;
      y = dq.pop_front();
      checks++;
      if (daddr !== y.a || dwe !== y.we || dsel !== y.sel || dlock !== 1'b1 || sbb !== y.sb ||
          (dwd & y.wm) !== (y.wd & y.wm)) bad("data port");
    end
  end
  // swap: note both halves for codes 0 and 2, run it with the pipe busy a while, then check status
  task automatic swp(input logic [31:0] ins, s1, s2, dv, ad, input logic bt, input logic [3:0] code);
    logic [3:0]  ix;
    logic [1:0]  ln;
    logic [31:0] wm, old;
    int          t;
    ix = ad[5:2];
    ln = ad[1:0];
    wm = bt ? 32'hFF << (8 * ln) : ALL;
    old = bt ? {24'h0, sh[ix][8*ln+:8]} : sh[ix];
    if (code == 4'h0 || code == 4'h2) begin
      dq.push_back('{ad, 1'b0, bt ? 4'h1 << ln : 4'hF, 32'h0, 32'h0, 32'h20});
      dq.push_back('{ad, 1'b1, bt ? 4'h1 << ln : 4'hF, bt ? {4{dv[7:0]}} : dv, wm, 32'h0});
    end
    if (code == 4'h0 && bt) sh[ix][8*ln+:8] = dv[7:0];
    if (code == 4'h0 && !bt) sh[ix] = dv;
    lat <= 2'($random(seed));
    pbusy <= 1'b1;
    iss(ins, s1, s2, dv);
    repeat (5) @(posedge clk);
    pbusy <= 1'b0;
    for (t = 0; dq.size() != 0 && t < 200; t++) @(posedge clk);
    if (t >= 200) bad("swap hang");
    repeat (2) @(posedge clk);
    rd(elad_pkg::ADR_STATUS, code == 4'h2 ? 32'h22 : {28'h0, code}, 32'h3F);
    if (code == 4'h0) rd(elad_pkg::ADR_RESULT, old, ALL);
    rd(elad_pkg::ADR_SBOARD, 32'h0, ALL);
  endtask : swp
  // main sequence
  initial begin
    {cyc, stb, we, pbusy, lerr, rstn, adr, sel, wdat, lat} = '0;
    for (int i = 0; i < 16; i++) sh[i] = 32'hC0DE0000 | i;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(elad_pkg::ADR_CTRL, {29'h0, elad_pkg::CTL_RST}, 32'h7);
    rd(elad_pkg::ADR_SBOARD, 32'h0, ALL);
    wr(8'h40, ALL);
    rd(8'h40, 32'h0, ALL);
    $display("reset done");
    for (int k = 0; k < 6; k++) begin
      a = $random(seed);
      b = $random(seed);
      r = lg(ops[k % 3], a, {16'h0, b[15:0]});
      iss({ops[k % 3], k > 2, 5'h03, 5'h01, b[15:0]}, a, 32'h0, 32'h0);
      if (k > 2) r = lg(ops[k % 3], a, {b[15:0], 16'h0});
      rd(elad_pkg::ADR_RESULT, k > 2 ? {r[31:16], a[15:0]} : {a[31:16], r[15:0]}, ALL);
      iss(rr(elad_pkg::P_REG, 5'h03, 5'h01, {ops[k % 3], k > 2, 5'h00}, 5'h02), a, b, 32'h0);
      rd(elad_pkg::ADR_RESULT, lg(ops[k % 3], a, k > 2 ? ~b : b), ALL);
    end
    $display("logic done");
    for (int k = 0; k < 7; k++) begin
      a = $random(seed) & 32'h3FFFFFFF;
      b = ($random(seed) & 32'hFFF) | 32'h1;
      iss({3'b011, 3'(k), 5'h03, 5'h01, b[15:0]}, a, 32'h0, 32'h0);
      rd(elad_pkg::ADR_RESULT, ar(3'(k), a, b), ALL);
      iss(rr(elad_pkg::P_REG, 5'h03, 5'h01, {3'b011, 3'(k), 1'b0, k[1], 3'h0}, 5'h02), a, b, 32'h0);
      rd(elad_pkg::ADR_RESULT, ar(3'(k), a, b), ALL);
    end
    wr(elad_pkg::ADR_CTRL, 32'h3);
    iss(rr(elad_pkg::P_REG, 5'h03, 5'h01, 11'h310, 5'h02), a, b, 32'h0);
    rd(elad_pkg::ADR_RESULT, a + b + 32'h1, ALL);
    iss(rr(elad_pkg::P_REG, 5'h03, 5'h01, 11'h308, 5'h02), ALL, 32'h2, 32'h0);
    rd(elad_pkg::ADR_CTRL, 32'h3, 32'h7);
    iss(rr(elad_pkg::P_REG, 5'h03, 5'h01, 11'h308, 5'h02), 32'h1, 32'h1, 32'h0);
    rd(elad_pkg::ADR_CTRL, 32'h1, 32'h7);
    iss(rr(elad_pkg::P_REG, 5'h03, 5'h01, 11'h330, 5'h02), a, b, 32'h0);
    rd(elad_pkg::ADR_RESULT, a - b - 32'h1, ALL);
    $display("arith done");
    iss(xc(3'h0), a, a, 32'h0);
    iss(xc(3'h0), b, b, 32'h0);
    rd(elad_pkg::ADR_RESULT, a, ALL);
    wr(elad_pkg::ADR_CTRL, 32'h0);
    iss(xc(3'h0), r, r, 32'h0);
    rd(elad_pkg::ADR_STATUS, 32'h1, 32'hF);
    iss(xc(3'h1), r, r, 32'h0);
    rd(elad_pkg::ADR_STATUS, 32'h0, 32'hF);
    iss(xc(3'h5), r, r, 32'h0);
    rd(elad_pkg::ADR_STATUS, {22'h0, 3'h5, 7'h04}, 32'h3FF);
    wr(elad_pkg::ADR_CTRL, 32'h1);
    iss(xc(3'h0), a, a, 32'h0);
    rd(elad_pkg::ADR_RESULT, b, ALL);
    for (int u = 2; u < 8; u++) begin
      iss(rr({3'b100, 3'(u)}, 5'h02, 5'h01, 11'h0, 5'h03), a, b, 32'h0);
      rd(elad_pkg::ADR_STATUS, {22'h0, 3'(u), 7'h04}, 32'h3FF);
    end
    for (int s = 0; s < 2; s++) begin
      iss(rr(6'h21, 5'h02, 5'h01, {5'h05, {3{1'b0, s[0]}}}, 5'h03), a, b, 32'h0);
      rd(elad_pkg::ADR_STATUS, s ? 32'h150040 : 32'h40, 32'h3F004F);
    end
    iss(rr(6'h21, 5'h00, 5'h01, 11'h0A0, 5'h03), a, b, 32'h0);
    rd(elad_pkg::ADR_STATUS, 32'h5, 32'hF);
    iss(rr(6'h20, 5'h00, 5'h01, 11'h643, 5'h01), a, a, 32'h0);
    rd(elad_pkg::ADR_STATUS, 32'h0, 32'hF);
    $display("coprocessor done");
    swp(32'h04A10008, 32'h100, 32'h0, $random(seed), 32'h108, 1'b0, 4'h0);
    swp(32'h00A10003, 32'h120, 32'h0, $random(seed), 32'h123, 1'b1, 4'h0);
    swp(rr(elad_pkg::P_REG, 5'h05, 5'h01, 11'h030, 5'h02), 32'h100, 32'h3, $random(seed), 32'h10C, 1'b0, 4'h0);
    swp(rr(elad_pkg::P_REG, 5'h05, 5'h01, 11'h010, 5'h02), 32'h101, 32'h6, $random(seed), 32'h107, 1'b1, 4'h0);
    swp(rr(elad_pkg::P_REG, 5'h05, 5'h01, 11'h020, 5'h02), 32'h200, 32'hFFFFFF10, $random(seed), 32'h110, 1'b0,
        4'h0);
    swp(32'h04A10002, 32'h100, 32'h0, $random(seed), 32'h0, 1'b0, 4'h3);
    wr(elad_pkg::ADR_CTRL, 32'h5);
    swp(32'h04A10002, 32'h100, 32'h0, $random(seed), 32'h100, 1'b0, 4'h0);
    wr(elad_pkg::ADR_CTRL, 32'h0);
    swp(rr(elad_pkg::P_REG, 5'h05, 5'h01, 11'h028, 5'h02), 32'h100, 32'h4, $random(seed), 32'h0, 1'b0, 4'h1);
    wr(elad_pkg::ADR_CTRL, 32'h1);
    lerr <= 1'b1;
    swp(32'h04A10008, 32'h100, 32'h0, 32'h600DF00D, 32'h108, 1'b0, 4'h2);
    lerr <= 1'b0;
    swp(32'h04A10008, 32'h100, 32'h0, 32'h600DF00D, 32'h108, 1'b0, 4'h0);
    $display("swap done");
    end_sim();
  end
endmodule : elad_core_tb
`default_nettype wire
